//--- verilog/standby_mode_control.sv
`timescale 1ns/1ps
module standby_mode_control (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// request sources: irq0 irq1 irq2 irq4 interval watch
	input  wire logic [5:0]  srcReq,
	// clock gate, vector request and interrupt outputs
	output standby_pkg::gates_s gates,
	output logic             vectorReq,
	output logic             irq
);
	// ***************
	// bus decode
	// ***************
	wire wrEn = psel && penable && pwrite;
	wire rdEn = psel && penable && !pwrite;
	wire hitCtrl  = paddr == standby_pkg::CTRL_OFS;
	wire hitSel   = paddr == standby_pkg::SEL_OFS;
	wire hitStat  = paddr == standby_pkg::STATUS_OFS;
	wire hitIrqf  = paddr == standby_pkg::IRQF_OFS;
	wire hitIen   = paddr == standby_pkg::IEN_OFS;
	wire hitEvt   = paddr == standby_pkg::EVT_OFS;
	wire hitEmask = paddr == standby_pkg::EMASK_OFS;
	wire hitAny = hitCtrl | hitSel | hitStat | hitIrqf | hitIen | hitEvt | hitEmask;

	logic [5:0] reqSync;
	sync2 #(.W(standby_pkg::NUM_SRC)) uSync (
		.clk  (clk),
		.rst  (rst),
		.din  (srcReq),
		.dout (reqSync)
	);

	standby_pkg::mode_e mode_q;
	logic [3:0] sel_q;
	logic       sub_q;
	logic       mie_q;
	logic [5:0] ien_q;
	logic [5:0] irqf_q;
	logic [2:0] evt_q;
	logic [2:0] emask_q;

	// ***************
	// source gating
	// ***************
	// irq0 deaf in standby
	// irq zero blocked
	wire standby = mode_q != standby_pkg::RUN;
	wire [5:0] live = {reqSync[5:1], reqSync[0] & !standby};
	wire [5:0] irqfSet = live;
	wire [5:0] pend = irqf_q & ien_q;
	wire wake = |pend;
	wire vec = wake && mie_q && !standby;

	wire stopReq = wrEn && hitCtrl && pwdata[standby_pkg::CTRL_STOP];
	wire haltReq = wrEn && hitCtrl && pwdata[standby_pkg::CTRL_HALT];
	// stop only on main clock
	// the written clock bit decides, so a switch to sub plus stop in one write is refused
	wire stopSub = stopReq && pwdata[standby_pkg::CTRL_SUB];
	wire stopOk = stopReq && !stopSub && !wake;
	wire haltOk = haltReq && !stopReq && !wake;
	wire modeEvt = stopOk | haltOk;
	wire rejEvt = stopSub;

	// ***************
	// mode machine
	// ***************
	standby_pkg::mode_e mode_d;
	always_comb begin
		mode_d = mode_q;
		unique case (mode_q)
			standby_pkg::RUN: begin
				if (stopOk)
					mode_d = standby_pkg::STOPPED;
				else if (haltOk)
					mode_d = standby_pkg::HALTED;
			end
			standby_pkg::HALTED, standby_pkg::STOPPED: begin
				if (wake)
					mode_d = standby_pkg::RUN;
			end
			default: mode_d = standby_pkg::RUN;
		endcase
	end

	// events: release, entry, rejected stop
	wire [2:0] evtSet = {rejEvt, modeEvt, standby && wake};
	wire readEvt = rdEn && hitEvt;
	wire [2:0] evt_d = evtSet | (readEvt ? 3'h0 : evt_q);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_q <= standby_pkg::RUN;
		end else begin
			mode_q <= mode_d;
		end
	end

	// control registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sel_q   <= standby_pkg::SEL_RST;
			sub_q   <= 1'b0;
			mie_q   <= 1'b0;
			ien_q   <= standby_pkg::IEN_RST;
			emask_q <= standby_pkg::EMASK_RST;
		end else begin
			if (wrEn && hitSel)
				sel_q <= pwdata[3:0];
			if (wrEn && hitCtrl) begin
				sub_q <= pwdata[standby_pkg::CTRL_SUB];
				mie_q <= pwdata[standby_pkg::CTRL_MIE];
			end
			if (wrEn && hitIen)
				ien_q <= pwdata[5:0];
			if (wrEn && hitEmask)
				emask_q <= pwdata[2:0];
		end
	end

	// request flags: set wins over clear
	// flags kept for polling
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irqf_q <= '0;
		end else begin
			irqf_q <= irqfSet | (irqf_q & ~((wrEn && hitIrqf) ? pwdata[5:0] : 6'h00));
		end
	end

	// sticky events cleared on read, set wins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			evt_q <= '0;
		end else begin
			evt_q <= evt_d;
		end
	end

	// ***************
	// clock gates
	// ***************
	standby_pkg::gates_s gates_d;
	wire mainOn = mode_d != standby_pkg::STOPPED;
	wire stopD  = mode_d == standby_pkg::STOPPED;
	always_comb begin
		gates_d.cpu = mode_d == standby_pkg::RUN;
		gates_d.mainOsc = mainOn;
		gates_d.intervalTimer = mainOn;
		gates_d.serial = mainOn || sel_q[standby_pkg::SEL_SERX];
		gates_d.eventCounter = mainOn || sel_q[standby_pkg::SEL_TPIN];
		gates_d.watchTimer = !stopD || sel_q[standby_pkg::SEL_WSUB];
		gates_d.display = !stopD || sel_q[standby_pkg::SEL_DSUB];
		gates_d.irqZero = mode_d == standby_pkg::RUN;
	end

	// ***************
	// outputs
	// ***************
	logic [31:0] rdMux;
	always_comb begin
		rdMux = 32'h0000_0000;
		if (hitCtrl)
			rdMux = {28'h0, mie_q, sub_q, 2'b00};
		else if (hitSel)
			rdMux = {28'h0, sel_q};
		else if (hitStat)
			rdMux = {30'h0, mode_q};
		else if (hitIrqf)
			rdMux = {26'h0, irqf_q};
		else if (hitIen)
			rdMux = {26'h0, ien_q};
		else if (hitEvt)
			rdMux = {29'h0, evt_q | evtSet}; // event in setup cycle not lost to the clear
		else if (hitEmask)
			rdMux = {29'h0, emask_q};
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata    <= '0;
			pready    <= 1'b0;
			pslverr   <= 1'b0;
			gates     <= '0;
			vectorReq <= 1'b0;
			irq       <= 1'b0;
		end else begin
			pready    <= psel && !penable;
			pslverr   <= psel && !penable && !hitAny;
			prdata    <= (psel && !penable && !pwrite) ? rdMux : 32'h0;
			gates     <= gates_d;
			vectorReq <= vec;
			irq       <= |(evt_d & emask_q);
		end
	end

	// ***************
	// checks
	// ***************
	property p_stopSub;
		@(posedge clk) disable iff (rst)
		(mode_q == standby_pkg::RUN && stopSub) |=> mode_q != standby_pkg::STOPPED;
	endproperty
	a_stopSub: assert property (p_stopSub) else $error("stop entered on sub clock");

	property p_halt;
		@(posedge clk) disable iff (rst)
		(mode_q == standby_pkg::RUN && haltReq && !stopReq && !wake) |=>
			mode_q == standby_pkg::HALTED;
	endproperty
	a_halt: assert property (p_halt) else $error("halt not entered");

	// gates launch with mode_q at the same edge, so both are compared in one cycle
	property p_stopMain;
		@(posedge clk) disable iff (rst)
		mode_q == standby_pkg::STOPPED |-> !gates.mainOsc;
	endproperty
	a_stopMain: assert property (p_stopMain) else $error("main clock ran in stop");

	property p_haltCpu;
		@(posedge clk) disable iff (rst)
		(mode_q == standby_pkg::HALTED && mode_d == standby_pkg::HALTED) |=>
			!gates.cpu && gates.mainOsc && gates.intervalTimer;
	endproperty
	a_haltCpu: assert property (p_haltCpu) else $error("halt gating wrong");

	property p_timerStop;
		@(posedge clk) disable iff (rst)
		stopD |=> !gates.intervalTimer;
	endproperty
	a_timerStop: assert property (p_timerStop) else $error("interval timer ran in stop");

	property p_serialStop;
		@(posedge clk) disable iff (rst)
		(stopD && !sel_q[standby_pkg::SEL_SERX]) |=> !gates.serial;
	endproperty
	a_serialStop: assert property (p_serialStop) else $error("serial ran in stop");

	property p_countStop;
		@(posedge clk) disable iff (rst)
		(stopD && !sel_q[standby_pkg::SEL_TPIN]) |=> !gates.eventCounter;
	endproperty
	a_countStop: assert property (p_countStop) else $error("counter ran in stop");

	property p_watch;
		@(posedge clk) disable iff (rst)
		(stopD && !sel_q[standby_pkg::SEL_WSUB]) |=> !gates.watchTimer;
	endproperty
	a_watch: assert property (p_watch) else $error("watch ran without sub clock");

	property p_dispStop;
		@(posedge clk) disable iff (rst)
		(stopD && !sel_q[standby_pkg::SEL_DSUB]) |=> !gates.display;
	endproperty
	a_dispStop: assert property (p_dispStop) else $error("display ran in stop");

	property p_irq0;
		@(posedge clk) disable iff (rst)
		(standby && reqSync[0] && !irqf_q[0]) |=> !irqf_q[0];
	endproperty
	a_irq0: assert property (p_irq0) else $error("irq zero acted in standby");

	sequence s_wakeSeen;
		standby && wake;
	endsequence
	property p_release;
		@(posedge clk) disable iff (rst)
		s_wakeSeen |=> mode_q == standby_pkg::RUN && gates.cpu;
	endproperty
	a_release: assert property (p_release) else $error("standby not released");

	property p_haltRun;
		@(posedge clk) disable iff (rst)
		(mode_d == standby_pkg::HALTED) |=>
			gates.intervalTimer && gates.serial && gates.eventCounter;
	endproperty
	a_haltRun: assert property (p_haltRun) else $error("halt peripherals gated");

	property p_vector;
		@(posedge clk) disable iff (rst)
		vectorReq |-> $past(mie_q) && $past(wake) && !$past(standby);
	endproperty
	a_vector: assert property (p_vector) else $error("vector without enables");

	property p_cpuOff;
		@(posedge clk) disable iff (rst)
		(mode_q != standby_pkg::RUN && !wake) |=> !gates.cpu;
	endproperty
	a_cpuOff: assert property (p_cpuOff) else $error("cpu ran in standby");
endmodule

//--- common/standby_pkg.sv
// Behaviour
// - stop accepted only on main clock
// - halt accepted on either clock
// - stop gates main clock and every unit not pin fed or sub clocked
// - halt gates only cpu clock and irq zero
// - interval timer stops in stop, runs halt
// - serial runs in stop only external clock
// - event counter in stop only pin clock
// - watch timer in stop needs sub clock
// - display in stop needs sub clock
// - irq one two four work in standby
// - reset or enabled request releases standby
// - halt peripherals need main oscillation
// - vector needs source and master enable
// - request flags readable by software
package standby_pkg;
	// ***************
	// register map
	// ***************
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] SEL_OFS    = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;
	localparam logic [7:0] IRQF_OFS   = 8'h0C;
	localparam logic [7:0] IEN_OFS    = 8'h10;
	localparam logic [7:0] EVT_OFS    = 8'h14;
	localparam logic [7:0] EMASK_OFS  = 8'h18;
	// field positions
	localparam int CTRL_STOP  = 0;
	localparam int CTRL_HALT  = 1;
	localparam int CTRL_SUB   = 2;
	localparam int CTRL_MIE   = 3;
	localparam int SEL_SERX   = 0;
	localparam int SEL_TPIN   = 1;
	localparam int SEL_WSUB   = 2;
	localparam int SEL_DSUB   = 3;
	localparam int NUM_SRC    = 6;
	// source indices
	localparam int SRC_IRQ0   = 0;
	localparam int SRC_IRQ1   = 1;
	localparam int SRC_IRQ2   = 2;
	localparam int SRC_IRQ4   = 3;
	localparam int SRC_BT     = 4;
	localparam int SRC_WT     = 5;
	// reset values
	localparam logic [3:0] SEL_RST  = 4'h0;
	localparam logic [5:0] IEN_RST  = 6'h00;
	localparam logic [2:0] EMASK_RST = 3'h0;

	typedef enum logic [1:0] {RUN, HALTED, STOPPED} mode_e;

	// peripheral clock enables
	typedef struct packed {
		logic cpu;
		logic mainOsc;
		logic intervalTimer;
		logic serial;
		logic eventCounter;
		logic watchTimer;
		logic display;
		logic irqZero;
	} gates_s;
endpackage

//--- verilog/sync2.sv
`timescale 1ns/1ps
// two-flop synchroniser bank
module sync2 #(
	parameter int W = 6
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_q;

	// first stage read only by second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= '0;
			dout   <= '0;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule

//--- verification/tb_standby_mode_control.sv
`timescale 1ns/1ps
module tb_standby_mode_control;
	// ***
	// bench state
	// ***
	logic                clk;
	logic                rst;
	logic                psel;
	logic                penable;
	logic                pwrite;
	logic                pready;
	logic                pslverr;
	logic                err;
	logic                vectorReq;
	logic                irq;
	logic [3:0]          s;
	logic [7:0]          paddr;
	logic [7:0]          gv;
	logic [31:0]         pwdata;
	logic [31:0]         prdata;
	logic [31:0]         rd;
	logic [5:0]          srcReq;
	standby_pkg::gates_s gates;
	int                  failures;
	int                  checked;
	int                  seed;
	int                  n;

	assign gv = gates;

	standby_mode_control uut (
		.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .srcReq(srcReq), .gates(gates),
		.vectorReq(vectorReq), .irq(irq)
	);

	// free running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			failures++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask

	// apb transfer, waits on pready instead of assuming zero wait
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) failures++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic gc(input logic [7:0] m, input logic [7:0] e);
		cmp({24'h0, gv & m}, {24'h0, e});
	endtask

	// only pin fed or sub clocked units survive stop
	function automatic logic [7:0] stopG(input logic [3:0] x);
		return {3'b000, x[0], x[1], x[2], x[3], 1'b0};
	endfunction

	// raise one source, expect cpu clock back within a bound
	task automatic rel(input int b);
		srcReq <= 6'h01 << b;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (gv[7] !== 1'b1 && n < 12);
		cmp({31'h0, gv[7]}, 32'h1);
		srcReq <= 6'h00;
		// flags stay set while the synced level is high
		repeat (4) @(posedge clk);
		bus(1'b1, 8'h0C, 32'h3F);
	endtask

	task automatic end_of_test;
		if (failures == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		end_of_test;
	end

	initial begin
		seed = 38;
		failures = 0;
		checked = 0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		srcReq = 6'h00;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		bus(1'b0, 8'h08, 32'h0);
		cmp(rd, 32'h0);
		gc(8'h80, 8'h80);
		bus(1'b0, 8'h1C, 32'h0);
		cmp({31'h0, err}, 32'h1);
		// stop on sub clock refused, event raises irq
		bus(1'b1, 8'h18, 32'h4);
		bus(1'b1, 8'h00, 32'h5);
		bus(1'b0, 8'h08, 32'h0);
		cmp(rd, 32'h0);
		cmp({31'h0, irq}, 32'h1);
		bus(1'b0, 8'h14, 32'h0);
		cmp(rd & 32'h4, 32'h4);
		bus(1'b0, 8'h08, 32'h0);
		cmp({31'h0, irq}, 32'h0);
		bus(1'b1, 8'h18, 32'h0);
		bus(1'b1, 8'h00, 32'h5);
		bus(1'b0, 8'h14, 32'h0);
		cmp({31'h0, irq}, 32'h0);
		bus(1'b1, 8'h00, 32'h0);
		bus(1'b1, 8'h10, 32'h3F);
		bus(1'b1, 8'h00, 32'h2);
		bus(1'b0, 8'h08, 32'h0);
		cmp(rd, 32'h1);
		gc(8'hFF, 8'h7E);
		bus(1'b0, 8'h14, 32'h0);
		cmp(rd, 32'h2);
		cmp({31'h0, vectorReq}, 32'h0);
		rel(1);
		bus(1'b0, 8'h14, 32'h0);
		cmp(rd, 32'h1);
		bus(1'b0, 8'h08, 32'h0);
		cmp(rd, 32'h0);
		srcReq <= 6'h04;
		repeat (4) @(posedge clk);
		bus(1'b0, 8'h0C, 32'h0);
		cmp(rd & 32'h4, 32'h4);
		cmp({31'h0, vectorReq}, 32'h0);
		bus(1'b1, 8'h00, 32'h8);
		bus(1'b0, 8'h08, 32'h0);
		cmp({31'h0, vectorReq}, 32'h1);
		srcReq <= 6'h00;
		repeat (4) @(posedge clk);
		bus(1'b1, 8'h0C, 32'h3F);
		bus(1'b0, 8'h08, 32'h0);
		cmp({31'h0, vectorReq}, 32'h0);
		bus(1'b1, 8'h00, 32'h0);
		for (int i = 0; i < 6; i++) begin
			s = 4'($random(seed));
			bus(1'b1, 8'h04, {28'h0, s});
			bus(1'b1, 8'h00, 32'h1);
			bus(1'b0, 8'h08, 32'h0);
			cmp(rd, 32'h2);
			gc(8'hFF, stopG(s));
			srcReq <= 6'h01;
			repeat (6) @(posedge clk);
			srcReq <= 6'h00;
			bus(1'b0, 8'h08, 32'h0);
			cmp(rd, 32'h2);
			rel(i % 5 + 1);
			bus(1'b0, 8'h08, 32'h0);
			cmp(rd, 32'h0);
		end
		// halt while on the sub clock
		bus(1'b1, 8'h00, 32'h6);
		bus(1'b0, 8'h08, 32'h0);
		cmp(rd, 32'h1);
		gc(8'h86, 8'h06);
		rel(3);
		end_of_test;
	end
endmodule
